/* cmp_defines.svh */
// offsets, field positions and reset values of the comparator block
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

`define CMP_NUM             3
`define CMP_ADR_W           8

`define CMP_CTRL0_OFS       8'h00
`define CMP_CTRL1_OFS       8'h04
`define CMP_CTRL2_OFS       8'h08
`define CMP_STATUS_OFS      8'h0C
`define CMP_IRQ_STAT_OFS    8'h10
`define CMP_IRQ_MASK_OFS    8'h14

`define CMP_CTRL_ON_BIT     15
`define CMP_CTRL_PIN_BIT    14
`define CMP_CTRL_INV_BIT    13
`define CMP_CTRL_FLAG_BIT   9
`define CMP_CTRL_RES_BIT    8
`define CMP_CTRL_EDGE_HI    7
`define CMP_CTRL_EDGE_LO    6
`define CMP_CTRL_REF_BIT    4
`define CMP_CTRL_CH_HI      1
`define CMP_CTRL_CH_LO      0

`define CMP_STAT_RES_LO     8
`define CMP_STAT_FLAG_LO    0

`define CMP_EDGE_OFF        2'h0
`define CMP_EDGE_RISE       2'h1
`define CMP_EDGE_FALL       2'h2
`define CMP_EDGE_ANY        2'h3

`define CMP_CTRL_RESET      16'h0000
`define CMP_DATA_ZERO       32'h0000_0000

`endif

/* cmp_pkg.sv */
// types shared by the comparator block
package cmp_pkg;

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

   typedef struct packed {
      logic       on;
      logic       pin_out;
      logic       invert;
      logic       flag;
      logic [1:0] edge_sel;
      logic       ref_sel;
      logic [1:0] chan;
   } ctrl_t;

   typedef struct packed {
      logic       on;
      logic       ref_sel;
      logic [1:0] chan;
   } ana_ctrl_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      bus_state_t      bus_st;
      wb_rsp_t         rsp;
      ctrl_t     [2:0] ctrl;
      logic      [2:0] prev;
      logic      [2:0] irq_stat;
      logic      [2:0] irq_mask;
      logic            irq;
      ana_ctrl_t [2:0] ana;
      logic      [2:0] pin_oe;
   } main_state_t;

endpackage

/* cmp_sync.sv */
// two-flop synchroniser for the raw comparator results
`timescale 1ns/1ps
module cmp_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;
endmodule

/* cmp_event.sv */
// edge decode for one comparator event
`timescale 1ns/1ps
`include "cmp_defines.svh"
module cmp_event (
   input  wire logic       on,
   input  wire logic       flag,
   input  wire logic [1:0] edge_sel,
   input  wire logic       prev,
   input  wire logic       cur,
   output logic            hit
);
   logic edge_seen;

   always_comb begin
      case (edge_sel)
         `CMP_EDGE_FALL: edge_seen = prev & ~cur;
         `CMP_EDGE_RISE: edge_seen = ~prev & cur;
         `CMP_EDGE_ANY:  edge_seen = prev ^ cur;
         default:        edge_seen = 1'b0;
      endcase
      hit = on & ~flag & edge_seen;
   end
endmodule

/* cmp_top.sv */
// control, event and register logic of three comparators
`timescale 1ns/1ps
`include "cmp_defines.svh"
module cmp_top (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire cmp_pkg::wb_req_t         wb_req,
   output cmp_pkg::wb_rsp_t              wb_rsp,
   input  wire logic               [2:0] cmp_raw,
   output cmp_pkg::ana_ctrl_t      [2:0] ana_ctrl,
   output logic                    [2:0] result_pin_oe,
   output logic                          irq
);
   cmp_pkg::main_state_t st_q;
   cmp_pkg::main_state_t st_d;

   logic [2:0] raw_sync;
   logic [2:0] cur_res;
   logic [2:0] hit;

   // pack one control word for reading
   function automatic logic [15:0] ctrl_pack(input cmp_pkg::ctrl_t c,
                                             input logic res);
      logic [15:0] w;
      w = `CMP_CTRL_RESET;
      w[`CMP_CTRL_ON_BIT]                   = c.on;
      w[`CMP_CTRL_PIN_BIT]                  = c.pin_out;
      w[`CMP_CTRL_INV_BIT]                  = c.invert;
      w[`CMP_CTRL_FLAG_BIT]                 = c.flag;
      w[`CMP_CTRL_RES_BIT]                  = res;
      w[`CMP_CTRL_EDGE_HI:`CMP_CTRL_EDGE_LO] = c.edge_sel;
      w[`CMP_CTRL_REF_BIT]                  = c.ref_sel;
      w[`CMP_CTRL_CH_HI:`CMP_CTRL_CH_LO]     = c.chan;
      return w;
   endfunction

   // merge a write into a control word by byte lane
   function automatic cmp_pkg::ctrl_t ctrl_write(input cmp_pkg::ctrl_t c,
                                                 input logic [15:0] w,
                                                 input logic [1:0] sel);
      cmp_pkg::ctrl_t n;
      n = c;
      if (sel[1]) begin
         n.on      = w[`CMP_CTRL_ON_BIT];
         n.pin_out = w[`CMP_CTRL_PIN_BIT];
         n.invert  = w[`CMP_CTRL_INV_BIT];
         n.flag    = w[`CMP_CTRL_FLAG_BIT];
      end
      if (sel[0]) begin
         n.edge_sel = w[`CMP_CTRL_EDGE_HI:`CMP_CTRL_EDGE_LO];
         n.ref_sel  = w[`CMP_CTRL_REF_BIT];
         n.chan     = w[`CMP_CTRL_CH_HI:`CMP_CTRL_CH_LO];
      end
      return n;
   endfunction

   // word index of a control register, or 3 if none
   function automatic logic [1:0] ctrl_index(input logic [7:0] adr);
      case (adr)
         `CMP_CTRL0_OFS: ctrl_index = 2'h0;
         `CMP_CTRL1_OFS: ctrl_index = 2'h1;
         `CMP_CTRL2_OFS: ctrl_index = 2'h2;
         default:        ctrl_index = 2'h3;
      endcase
   endfunction

   cmp_sync #(
      .WIDTH    (3)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (cmp_raw),
      .sync_out (raw_sync)
   );

   // polarity applied after synchronising
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         cur_res[i] = st_q.ctrl[i].on &
                      (raw_sync[i] ^ st_q.ctrl[i].invert);
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_evt
      cmp_event u_evt (
         .on       (st_q.ctrl[g].on),
         .flag     (st_q.ctrl[g].flag),
         .edge_sel (st_q.ctrl[g].edge_sel),
         .prev     (st_q.prev[g]),
         .cur      (cur_res[g]),
         .hit      (hit[g])
      );
   end

   logic        req;
   logic        wr;
   logic [1:0]  idx;
   logic [31:0] rdat;
   logic [2:0]  w1c;

   always_comb begin
      req  = wb_req.cyc & wb_req.stb;
      idx  = ctrl_index(wb_req.adr);
      rdat = `CMP_DATA_ZERO;
      case (wb_req.adr)
         `CMP_CTRL0_OFS, `CMP_CTRL1_OFS, `CMP_CTRL2_OFS: begin
            rdat[15:0] = ctrl_pack(st_q.ctrl[idx], cur_res[idx]);
         end
         `CMP_STATUS_OFS: begin
            rdat[`CMP_STAT_RES_LO +: 3] = cur_res;
            for (int i = 0; i < 3; i++) begin
               rdat[`CMP_STAT_FLAG_LO + i] = st_q.ctrl[i].flag;
            end
         end
         `CMP_IRQ_STAT_OFS: rdat[2:0] = st_q.irq_stat;
         `CMP_IRQ_MASK_OFS: rdat[2:0] = st_q.irq_mask;
         default:           rdat = `CMP_DATA_ZERO;
      endcase
   end

   always_comb begin
      st_d = st_q;
      wr   = 1'b0;
      w1c  = 3'h0;
      st_d.prev = cur_res;
      case (st_q.bus_st)
         cmp_pkg::BUS_IDLE: begin
            st_d.rsp.ack = 1'b0;
            if (req) begin
               st_d.rsp.ack = 1'b1;
               st_d.rsp.dat = rdat;
               st_d.bus_st  = cmp_pkg::BUS_ACK;
            end
         end
         cmp_pkg::BUS_ACK: begin
            wr           = req & wb_req.we;
            st_d.rsp.ack = 1'b0;
            st_d.bus_st  = cmp_pkg::BUS_IDLE;
         end
         default: begin
            st_d.rsp.ack = 1'b0;
            st_d.bus_st  = cmp_pkg::BUS_IDLE;
         end
      endcase

      if (wr && idx != 2'h3) begin
         st_d.ctrl[idx] = ctrl_write(st_q.ctrl[idx], wb_req.dat[15:0],
                                     wb_req.sel[1:0]);
      end
      if (wr && wb_req.adr == `CMP_IRQ_STAT_OFS && wb_req.sel[0]) begin
         w1c = wb_req.dat[2:0];
      end
      if (wr && wb_req.adr == `CMP_IRQ_MASK_OFS && wb_req.sel[0]) begin
         st_d.irq_mask = wb_req.dat[2:0];
      end

      for (int i = 0; i < 3; i++) begin
         if (hit[i]) begin
            st_d.ctrl[i].flag = 1'b1;
         end
         st_d.ana[i].on      = st_d.ctrl[i].on;
         st_d.ana[i].ref_sel = st_d.ctrl[i].ref_sel;
         st_d.ana[i].chan    = st_d.ctrl[i].chan;
         st_d.pin_oe[i]      = st_d.ctrl[i].pin_out;
      end
      st_d.irq_stat = (st_q.irq_stat & ~w1c) | hit;
      st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_rsp        = st_q.rsp;
   assign ana_ctrl      = st_q.ana;
   assign result_pin_oe = st_q.pin_oe;
   assign irq           = st_q.irq;
endmodule

/* cmp_model.sv */
// behavioural model of the three analogue comparator cores
`timescale 1ns/1ps
module cmp_model (
   input  wire cmp_pkg::ana_ctrl_t [2:0] ana_ctrl,
   input  wire logic          [2:0][3:0] pos,
   output logic                    [2:0] cmp_raw
);
   // a core that is off gives a low result
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         cmp_raw[i] = ana_ctrl[i].on && pos[i][ana_ctrl[i].chan];
      end
   end
endmodule

/* cmp_top_chk.sv */
// port checker for the comparator block
`timescale 1ns/1ps
module cmp_top_chk (
   input wire logic                     clk,
   input wire logic                     rst,
   input wire cmp_pkg::wb_req_t         wb_req,
   input wire cmp_pkg::wb_rsp_t         wb_rsp,
   input wire logic               [2:0] cmp_raw,
   input wire cmp_pkg::ana_ctrl_t [2:0] ana_ctrl,
   input wire logic               [2:0] result_pin_oe,
   input wire logic                     irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic w0;
   logic rd;
   assign w0 = wb_rsp.ack && wb_req.we && wb_req.adr == 8'h00;
   assign rd = wb_rsp.ack && !wb_req.we;
   property p_ack;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
   endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_on;
      w0 && wb_req.sel[1] |=> ana_ctrl[0].on == $past(wb_req.dat[15]);
   endproperty
   a_on: assert property (p_on) else $error("enable lost");
   property p_pin;
      w0 && wb_req.sel[1] |=> result_pin_oe[0] == $past(wb_req.dat[14]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin enable");
   property p_sel;
      w0 && wb_req.sel[0] |=> {ana_ctrl[0].ref_sel, ana_ctrl[0].chan}
         == $past({wb_req.dat[4], wb_req.dat[1:0]});
   endproperty
   a_sel: assert property (p_sel) else $error("input select");
   property p_hold;
      !(wb_rsp.ack && wb_req.we) |=> $stable(ana_ctrl)
         && $stable(result_pin_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("ctrl moved");
   property p_rsv;
      rd && wb_req.adr < 8'h0C |-> (wb_rsp.dat & 32'hFFFF_1C2C) == 32'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_off;
      rd && wb_req.adr == 8'h00 && !ana_ctrl[0].on |-> !wb_rsp.dat[8];
   endproperty
   a_off: assert property (p_off) else $error("result while off");
   property p_irq;
      $rose(irq) |-> $past(wb_rsp.ack && wb_req.we)
         || $past(ana_ctrl[0].on || ana_ctrl[1].on || ana_ctrl[2].on);
   endproperty
   a_irq: assert property (p_irq) else $error("irq cause");
   c_wr: cover property (w0);
   c_irq: cover property ($rose(irq));
   c_pin: cover property ($rose(result_pin_oe[2]));
endmodule
bind cmp_top cmp_top_chk u_chk (.clk, .rst, .wb_req, .wb_rsp, .cmp_raw,
   .ana_ctrl, .result_pin_oe, .irq);

/* cmp_top_tb.sv */
// self-checking bench for the comparator block
`timescale 1ns/1ps
module cmp_top_tb;
   logic                     clk = 1'b0;
   logic                     rst = 1'b1;
   cmp_pkg::wb_req_t         req = '0;
   cmp_pkg::wb_rsp_t         rsp;
   cmp_pkg::ana_ctrl_t [2:0] ana;
   logic               [2:0] raw;
   logic               [2:0] oe;
   logic                     irq;
   logic          [2:0][3:0] pos = '0;
   logic              [31:0] v;
   logic              [15:0] c;
   logic                     h;
   int                       bad_count = 0;
   int                       tests_run = 0;
   always #2 clk = ~clk;
   cmp_top u_dut (.clk, .rst, .wb_req(req), .wb_rsp(rsp), .cmp_raw(raw),
      .ana_ctrl(ana), .result_pin_oe(oe), .irq);
   cmp_model u_core (.ana_ctrl(ana), .pos, .cmp_raw(raw));
   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("Error %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 20);
      v = rsp.dat;
      req <= '0;
      if (n >= 20) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1, 8'h18, 32'hFFFF);
      for (int a = 0; a < 28; a += 4) begin
         bus(0, a[7:0], 0);
         chk(v, 0);
      end
      $display("reset test done");
      bus(1, 8'h08, 32'hC013);
      idle(1);
      chk({ana, oe}, {12'hF00, 3'b100});
      bus(0, 8'h08, 0);
      chk(v, 32'hC013);
      bus(1, 8'h08, 0);
      $display("config test done");
      bus(1, 8'h14, 1);
      for (int k = 0; k < 8; k++) begin
         c = 16'h8101 | 16'(k[0]) << 13 | 16'(k[2:1]) << 6;
         pos[0][1] <= 1'b0;
         bus(1, 0, c);
         idle(6);
         bus(1, 0, c);
         bus(1, 8'h10, 7);
         pos[0][1] <= 1'b1;
         idle(6);
         h = k[2:1] == 3 || k[2:1] == {k[0], !k[0]};
         bus(0, 8'h0C, 0);
         chk(v[10:0], {2'b0, !k[0], 7'h0, h});
         chk(irq, h);
         bus(1, 0, c);
         pos[0][1] <= 1'b0;
         idle(6);
         h = k[2:1] == 3 || k[2:1] == {!k[0], k[0]};
         bus(0, 0, 0);
         chk(v[9:8], {h, k[0]});
      end
      bus(1, 8'h10, 1);
      pos[0][1] <= 1'b1;
      idle(6);
      pos[0][1] <= 1'b0;
      idle(6);
      bus(0, 8'h10, 0);
      chk(v, 0);
      chk(irq, 0);
      bus(1, 0, c);
      pos[0][1] <= 1'b1;
      idle(6);
      chk(irq, 1);
      bus(1, 8'h14, 0);
      idle(1);
      chk(irq, 0);
      bus(1, 8'h10, 1);
      bus(0, 8'h10, 0);
      chk(v, 0);
      $display("event test done");
      wrap_up();
   end
endmodule
